/* File: cpu_ref_model.sv */
// Purpose: processor side issuing one reference at a time
// Assumes: start, then pause, then log settles
// Notes: address bus shows inverse once released
`timescale 1ns/10ps
module cpu_ref_model
(
  input wire clk_sys_i,
  input wire [17:0] pa_i,
  input wire abort_i,
  output reg start_o,
  output reg pause_o,
  output reg [15:0] va_o,
  output reg [15:0] pc_o,
  output reg [15:0] psw_o,
  output reg isp_o,
  output reg wr_o,
  output reg bus_end_condition_o
);
  // ==========================================
  // Abort vector words 250 and 252 (octal) in kernel data space
  localparam [15:0] VEC_PC_VA = 16'h00A8;
  localparam [15:0] VEC_PS_VA = 16'h00AA;
  // ==========================================
  // Reference cycle
  initial
  begin
    {start_o, pause_o, isp_o, wr_o, bus_end_condition_o} = 5'h00;
    {va_o, pc_o, psw_o} = 48'h0;
  end
  task run(input [15:0] v, input [1:0] m, input isp, input wr, input be, output [17:0] p, output a);
    @(posedge clk_sys_i);
    start_o <= 1'b1;
    va_o <= v;
    pc_o <= ~v;
    psw_o <= {m, 14'h0000};
    isp_o <= isp;
    wr_o <= wr;
    bus_end_condition_o <= be;
    @(posedge clk_sys_i);
    start_o <= 1'b0;
    va_o <= ~v;
    #1;
    p = pa_i;
    a = abort_i;
    @(posedge clk_sys_i);
    pause_o <= 1'b1;
    @(posedge clk_sys_i);
    pause_o <= 1'b0;
    bus_end_condition_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  // After an abort the processor fetches its new counter and status word
  task take_abort(output [17:0] p_pc, output [17:0] p_ps, output hit);
    reg a0;
    reg a1;
    run(VEC_PC_VA, 2'h0, 1'b0, 1'b0, 1'b0, p_pc, a0);
    run(VEC_PS_VA, 2'h0, 1'b0, 1'b0, 1'b0, p_ps, a1);
    hit = a0 | a1;
  endtask
endmodule // cpu_ref_model

/* File: page_check.v */
// Purpose: combinational access-key and length check for one reference
// Assumes: descriptor layout from page_relocation_defines.vh
// Notes: table-driven decode of the access key
`timescale 1ns/10ps
`include "page_relocation_defines.vh"
module page_check
(
  input wire [15:0] desc_i,
  input wire [6:0] block_i,
  input wire write_i,
  output reg non_res_o,
  output reg read_only_o,
  output reg length_o
);
  wire [6:0] len;
  wire down;
  assign len = desc_i[`DESC_LEN_HI:`DESC_LEN_LO];
  assign down = desc_i[`DESC_EXP_BIT];
  // =====================================================
  // Key table and length compare
  always @*
  begin
    non_res_o = 1'b0;
    read_only_o = 1'b0;
    case (desc_i[`DESC_KEY_HI:`DESC_KEY_LO]) // RULE_13
      `KEY_RDONLY: read_only_o = write_i; // RULE_01
      `KEY_RDWR: read_only_o = 1'b0;
      default: non_res_o = 1'b1; // RULE_01
    endcase
    // Upward pages hold blocks 0..len, downward pages len..127
    if (down)
      length_o = (block_i < len); // RULE_08
    else
      length_o = (block_i > len); // RULE_08
  end
endmodule // page_check

/* File: page_reloc_monitor.sv */
// Purpose: port checks for the page relocation logic
// Assumes: enable bit mirrored from status writes
// Notes: bench never logs and writes status together
`timescale 1ns/10ps
`include "page_relocation_defines.vh"
module page_reloc_monitor
(
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire start_i,
  input wire pause_i,
  input wire [15:0] virtual_address_i,
  input wire [15:0] inst_pc_i,
  input wire [15:0] processor_status_word_i,
  input wire i_space_i,
  input wire write_i,
  input wire bus_end_condition_i,
  input wire [17:0] physical_address_o,
  input wire abort_o,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================
  // Helpers
  reg en_reg;
  reg [15:0] va_reg;
  always @(posedge clk_sys_i)
  begin
    va_reg <= virtual_address_i;
    if (!rst_b_i)
      en_reg <= 1'b0;
    else if (reg_wr_i && reg_addr_i == `ADDR_STATUS0)
      en_reg <= reg_wdata_i[`ST0_ENABLE];
  end
  abort_pulse_a: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  abort_cause_a: assert property (abort_o |-> $past(start_i) && !$past(bus_end_condition_i))
    else $error("abort without a live reference");
  bus_end_condition_quiet_a: assert property (start_i && bus_end_condition_i |=> !abort_o)
    else $error("abort despite bus end");
  off_keep_a: assert property (start_i |=> physical_address_o[5:0] == va_reg[5:0])
    else $error("word offset altered");
  pa_hold_a: assert property (!start_i |=> $stable(physical_address_o))
    else $error("address moved without a reference");
  pass_thru_a: assert property (start_i && !en_reg |=> physical_address_o == {2'b00, va_reg})
    else $error("disabled address not passed");
  off_quiet_a: assert property (start_i && !en_reg |=> !abort_o)
    else $error("abort while disabled");
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  reset_zero_a: assert property (disable iff (1'b0) !rst_b_i |=> !abort_o && physical_address_o == 18'h00000)
    else $error("outputs not cleared by reset");
endmodule // page_reloc_monitor
bind page_relocation_abort_logic page_reloc_monitor mon (.*);

/* File: page_relocation_abort_logic.v */
// Purpose: paged relocation, protection abort and abort logging
// Assumes: processor presents one reference per start pulse, then a pause phase
// Notes: register port is synchronous; read data one cycle after the strobe
//
// Behaviour
// [RULE_01] Abort nonresident, read-only write, or length violation
// [RULE_02] Abort allowed on any single reference
// [RULE_03] Log page, instruction address, and status
// [RULE_04] Processor vectors abort through kernel 250/252
// [RULE_05] Bus end suppresses abort for reference
// [RULE_06] Status bits 15:14 pick mode register set
// [RULE_07] Eight 4K-word pages in 32K space
// [RULE_08] Page length in 32-word blocks
// [RULE_09] Forty-eight base registers, sixteen per mode
// [RULE_10] Forty-eight descriptors, length, direction, key
// [RULE_11] Physical address is base-relocated virtual address
// [RULE_12] Status updates during pause half
// [RULE_13] Separate instruction/data space, table decode
// [RULE_14] Enabled: 16-bit virtual to 18-bit physical
// [RULE_15] Disabled: virtual passes through unchanged
// [RULE_16] Top three bits select page, rest offset
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "page_relocation_defines.vh"
module page_relocation_abort_logic
#(
  parameter MODES = 3,
  parameter PAGES_PER_MODE = 16
)
(
  input wire clk_sys_i,
  input wire rst_b_i,
  // Reference from the processor
  input wire start_i,
  input wire pause_i,
  input wire [15:0] virtual_address_i,
  input wire [15:0] inst_pc_i,
  input wire [15:0] processor_status_word_i,
  input wire i_space_i,
  input wire write_i,
  input wire bus_end_condition_i,
  output reg [17:0] physical_address_o,
  output reg abort_o,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o
);
  localparam ENTRIES = 64;
  localparam ST_IDLE = 3'b001;
  localparam ST_START = 3'b010;
  localparam ST_PAUSE = 3'b100;

  reg [11:0] base_mem [0:ENTRIES-1];
  reg [15:0] desc_mem [0:ENTRIES-1];
  reg [15:0] status_register_zero_reg;
  reg [15:0] abort_va_reg;
  reg [15:0] abort_pc_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg pend_reg;
  reg [15:0] va_reg;
  reg [15:0] pc_reg;
  reg [3:0] page_reg;
  reg [1:0] mode_reg;
  reg nr_reg;
  reg ro_reg;
  reg len_reg;

  wire [1:0] mode;
  wire [1:0] set_idx;
  wire [3:0] page;
  wire [5:0] entry;
  wire [11:0] base_sel;
  wire [15:0] desc_sel;
  wire [17:0] relocated;
  wire non_res;
  wire read_only;
  wire too_long;
  wire fault;
  wire [5:0] reg_entry;
  wire [1:0] reg_group;

  // =====================================================
  // Register set and page selection
  assign mode = processor_status_word_i[15:14]; // RULE_06
  // User code 11 maps to set 2; the unused code 10 also lands there
  assign set_idx = (mode == `MODE_KERNEL) ? 2'h0 : ((mode == `MODE_SUPER) ? 2'h1 : 2'h2); // RULE_06
  // Instruction and data spaces each hold eight pages per mode
  assign page = {i_space_i ? 1'b0 : 1'b1, virtual_address_i[15:13]}; // RULE_13 RULE_16 RULE_07
  assign entry = {set_idx, page};
  assign base_sel = base_mem[entry];
  assign desc_sel = desc_mem[entry];
  // Base counts 32-word blocks; block offset plus byte-in-block
  assign relocated = {base_sel, 6'h00} + {5'h00, virtual_address_i[12:0]}; // RULE_11 RULE_14

  page_check u_check
  (
    .desc_i(desc_sel),
    .block_i(virtual_address_i[12:6]), // RULE_16
    .write_i(write_i),
    .non_res_o(non_res),
    .read_only_o(read_only),
    .length_o(too_long)
  );

  assign fault = status_register_zero_reg[`ST0_ENABLE] & (non_res | read_only | too_long) & ~bus_end_condition_i;

  assign reg_entry = reg_addr_i[5:0];
  assign reg_group = reg_addr_i[7:6];

  // =====================================================
  // Memory-cycle phase sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_i)
          state_next = ST_START;
      ST_START:
        if (pause_i)
          state_next = ST_PAUSE;
      ST_PAUSE:
        state_next = start_i ? ST_START : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // =====================================================
  // Reference capture, relocation, abort
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      physical_address_o <= 18'h00000;
      abort_o <= 1'b0;
      pend_reg <= 1'b0;
      va_reg <= 16'h0000;
      pc_reg <= 16'h0000;
      page_reg <= 4'h0;
      mode_reg <= 2'h0;
      nr_reg <= 1'b0;
      ro_reg <= 1'b0;
      len_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      abort_o <= 1'b0;
      if (start_i)
      begin
        if (status_register_zero_reg[`ST0_ENABLE])
          physical_address_o <= relocated; // RULE_11 RULE_14
        else
          physical_address_o <= {2'h0, virtual_address_i}; // RULE_15
        // Every reference is checked, so mid-instruction aborts occur
        abort_o <= fault; // RULE_01 RULE_02 RULE_05
        pend_reg <= fault;
        va_reg <= virtual_address_i;
        pc_reg <= inst_pc_i;
        page_reg <= page;
        mode_reg <= mode;
        nr_reg <= non_res;
        ro_reg <= read_only;
        len_reg <= too_long;
      end
      else if (state_reg == ST_PAUSE)
        pend_reg <= 1'b0;
      // A late bus end still cancels the logging
      if (bus_end_condition_i)
        pend_reg <= 1'b0; // RULE_05
    end
  end

  // =====================================================
  // Status and abort log registers
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      status_register_zero_reg <= `ST0_RESET;
      abort_va_reg <= 16'h0000;
      abort_pc_reg <= 16'h0000;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == `ADDR_STATUS0)
        status_register_zero_reg <= reg_wdata_i;
      // Logging in the pause half wins over a software write
      if (state_reg == ST_PAUSE && pend_reg && !bus_end_condition_i) // RULE_12
      begin
        // Flags freeze the log until software clears them
        if (status_register_zero_reg[15:13] == 3'h0)
        begin
          status_register_zero_reg[`ST0_ABORT_NR] <= nr_reg; // RULE_03
          status_register_zero_reg[`ST0_ABORT_RO] <= ro_reg; // RULE_03
          status_register_zero_reg[`ST0_ABORT_LEN] <= len_reg; // RULE_03
          status_register_zero_reg[`ST0_MODE_LO+1:`ST0_MODE_LO] <= mode_reg; // RULE_03
          status_register_zero_reg[`ST0_SPACE] <= page_reg[3]; // RULE_03
          status_register_zero_reg[`ST0_PAGE_LO+2:`ST0_PAGE_LO] <= page_reg[2:0]; // RULE_03
          abort_va_reg <= va_reg; // RULE_03
          abort_pc_reg <= pc_reg; // RULE_03
        end
      end
    end
  end

  // =====================================================
  // Base and descriptor arrays, one generate per entry
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1)
    begin : g_map
      always @(posedge clk_sys_i)
      begin
        if (!rst_b_i)
        begin
          base_mem[g] <= `BASE_RESET; // RULE_09
          desc_mem[g] <= `DESC_RESET; // RULE_10
        end
        else if (reg_wr_i && reg_entry == g && g < MODES * PAGES_PER_MODE)
        begin
          if (reg_group == `GROUP_BASE)
            base_mem[g] <= reg_wdata_i[11:0]; // RULE_09
          else if (reg_group == `GROUP_DESC)
            desc_mem[g] <= reg_wdata_i; // RULE_10
        end
      end
    end
  endgenerate

  // =====================================================
  // Read port; unmapped addresses read zero
  always @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      reg_rdata_o <= 16'h0000;
      if (reg_group == `GROUP_BASE && reg_entry < MODES * PAGES_PER_MODE)
        reg_rdata_o <= {4'h0, base_mem[reg_entry]};
      else if (reg_group == `GROUP_DESC && reg_entry < MODES * PAGES_PER_MODE)
        reg_rdata_o <= desc_mem[reg_entry];
      else if (reg_addr_i == `ADDR_STATUS0)
        reg_rdata_o <= status_register_zero_reg;
      else if (reg_addr_i == `ADDR_ABORT_VA)
        reg_rdata_o <= abort_va_reg;
      else if (reg_addr_i == `ADDR_ABORT_PC)
        reg_rdata_o <= abort_pc_reg;
    end
    else
      reg_rdata_o <= 16'h0000;
  end
endmodule // page_relocation_abort_logic

/* File: page_relocation_defines.vh */
// Purpose: constants for the page relocation and abort logic
// Assumes: included by bare name
// Notes: register offsets are word indices on the plain register port
`ifndef PAGE_RELOCATION_DEFINES_VH
`define PAGE_RELOCATION_DEFINES_VH
// =====================================================
// Mode codes from processor status bits 15:14
`define MODE_KERNEL 2'h0
`define MODE_SUPER 2'h1
`define MODE_USER 2'h3
// =====================================================
// Register map (word index on reg_addr_i, 8 bits)
`define ADDR_BASE_LO 8'h00
`define ADDR_DESC_LO 8'h40
`define ADDR_STATUS0 8'h80
`define ADDR_ABORT_VA 8'h81
`define ADDR_ABORT_PC 8'h82
`define ADDR_GROUP_MASK 8'hC0
`define GROUP_BASE 2'h0
`define GROUP_DESC 2'h1
// =====================================================
// Descriptor fields
`define DESC_LEN_HI 14
`define DESC_LEN_LO 8
`define DESC_EXP_BIT 3
`define DESC_KEY_HI 2
`define DESC_KEY_LO 1
// Access key codes
`define KEY_NONRES0 2'h0
`define KEY_RDONLY 2'h1
`define KEY_NONRES2 2'h2
`define KEY_RDWR 2'h3
// =====================================================
// Status register zero fields
`define ST0_ENABLE 0
`define ST0_PAGE_LO 1
`define ST0_SPACE 4
`define ST0_MODE_LO 5
`define ST0_ABORT_LEN 13
`define ST0_ABORT_RO 14
`define ST0_ABORT_NR 15
`define ST0_RESET 16'h0000
`define BASE_RESET 12'h000
`define DESC_RESET 16'h0000
`endif

/* File: test_page_relocation_abort_logic.sv */
// Purpose: self-checking bench for the page relocation logic
// Assumes: processor model drives the reference side
// Notes: register port driven here
`timescale 1ns/10ps
module test_page_relocation_abort_logic;
  reg clk_sys_i, rst_b_i, reg_wr_i, reg_rd_i;
  reg [7:0] reg_addr_i;
  reg [15:0] reg_wdata_i;
  wire st, pz, isp, wr, be, ab;
  wire [15:0] va, pc, psw, rdata;
  wire [17:0] pa;
  reg [17:0] p, q;
  reg a;
  integer n_fail, n_compared, m, s, e;
  page_relocation_abort_logic dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(st), .pause_i(pz),
    .virtual_address_i(va), .inst_pc_i(pc), .processor_status_word_i(psw), .i_space_i(isp), .write_i(wr),
    .bus_end_condition_i(be), .physical_address_o(pa), .abort_o(ab), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata));
  cpu_ref_model cpu (.clk_sys_i(clk_sys_i), .pa_i(pa), .abort_i(ab), .start_o(st), .pause_o(pz),
    .va_o(va), .pc_o(pc), .psw_o(psw), .isp_o(isp), .wr_o(wr), .bus_end_condition_o(be));
  // ==========================================
  // Shared tasks
  task chk(input [17:0] g, input [17:0] x);
    n_compared = n_compared + 1;
    if (g !== x)
    begin
      n_fail = n_fail + 1;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task wrr(input [7:0] ad, input [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rdc(input [7:0] ad, input [15:0] x);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({2'b00, rdata}, {2'b00, x});
  endtask
  task close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    rdc(8'h80, 16'h0000);
    wrr(8'h05, 16'h0ABC);
    rdc(8'h05, 16'h0ABC);
    wrr(8'h30, 16'h0123);
    rdc(8'h30, 16'h0000);
    $display("test regs done");
  endtask
  task t_pass;
    cpu.run(16'hF123, 2'h3, 1'b0, 1'b1, 1'b0, p, a);
    chk(p, 18'h0F123);
    chk(a, 1'b0);
    $display("test pass done");
  endtask
  task t_modes;
    wrr(8'h80, 16'h0001);
    for (m = 0; m < 6; m = m + 1)
    begin
      s = m % 3;
      e = s * 16 + ((m < 3) ? 10 : 2);
      wrr(e, 16'h0040 + e);
      wrr(8'h40 + e, 16'h7F06);
      cpu.run(16'h4ABC, (s == 2) ? 2'h3 : s, m >= 3, 1'b1, 1'b0, p, a);
      chk(p, {12'h040 + e, 6'h00} + 18'h00ABC);
      chk(a, 1'b0);
    end
    // Unused mode code 10 falls onto the user set
    cpu.run(16'h4ABC, 2'h2, 1'b1, 1'b1, 1'b0, p, a);
    chk(p, {12'h062, 6'h00} + 18'h00ABC);
    $display("test modes done");
  endtask
  task t_abort;
    // Kernel data page 0 holds the abort vector words
    wrr(8'h48, 16'h7F06);
    for (m = 0; m < 4; m = m + 1)
    begin
      wrr(8'h4A, (m == 0) ? 16'h7F02 : (m == 1) ? 16'h0106 : (m == 2) ? 16'h7F00 : 16'h030E);
      wrr(8'h80, 16'h0001);
      cpu.run(16'h4080, 2'h0, 1'b0, 1'b1, 1'b0, p, a);
      chk(a, 1'b1);
      cpu.take_abort(p, q, a);
      chk(p, 18'h000A8);
      chk(q, 18'h000AA);
      chk(a, 1'b0);
      rdc(8'h80, (m == 0) ? 16'h4015 : (m == 2) ? 16'h8015 : 16'h2015);
      rdc(8'h81, 16'h4080);
      rdc(8'h82, 16'hBF7F);
    end
    wrr(8'h80, 16'h0001);
    cpu.run(16'h4080, 2'h0, 1'b0, 1'b1, 1'b1, p, a);
    chk(a, 1'b0);
    rdc(8'h80, 16'h0001);
    $display("test abort done");
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail = n_fail + 1;
    close_out;
  end
  initial
  begin
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 27'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_pass;
    t_modes;
    t_abort;
    close_out;
  end
endmodule // test_page_relocation_abort_logic
